//--- src/wcb_top.v
// Write combining buffer: merges stores into one 64-byte line and drains it.
`timescale 1ns/1ns
`include "wcb_defines.vh"

module wcb_top (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // Store path
    input  wire         st_valid,
    input  wire [2:0]   st_type,
    input  wire [31:0]  st_addr,
    input  wire [3:0]   st_len,
    input  wire [63:0]  st_data,
    output wire         st_ready,
    // Closing events
    input  wire         ev_io,
    input  wire         ev_serialize,
    input  wire         ev_flush,
    input  wire         ev_lock_start,
    input  wire         ev_tlb_ad,
    // Read observation
    input  wire         rd_valid,
    input  wire [2:0]   rd_type,
    input  wire [31:0]  rd_addr,
    // Bus command
    output wire         cmd_valid,
    output wire [1:0]   cmd_kind,
    output wire [31:0]  cmd_addr,
    output wire [7:0]   cmd_mask,
    output wire [511:0] cmd_data,
    input  wire         cmd_ready,
    // Status
    output wire         wc_open,
    output wire         wc_wt_mode
);

    reg [1:0]   state_ff;
    reg         mode_wt_ff;
    reg [25:0]  line_ff;
    reg [31:0]  seq_ff;
    reg [63:0]  mask_ff;
    reg [511:0] data_ff;
    reg [4:0]   tmo_ff;
    reg         hold_v_ff;
    reg [2:0]   hold_type_ff;
    reg [31:0]  hold_addr_ff;
    reg [3:0]   hold_len_ff;
    reg [63:0]  hold_data_ff;
    reg         st_ready_ff;
    reg         open_ff;
    reg         start_ff;

    reg [1:0]   nxt_state;
    reg         nxt_mode_wt;
    reg [25:0]  nxt_line;
    reg [31:0]  nxt_seq;
    reg [63:0]  nxt_mask;
    reg [511:0] nxt_data;
    reg [4:0]   nxt_tmo;
    reg         nxt_hold_v;
    reg [2:0]   nxt_hold_type;
    reg [31:0]  nxt_hold_addr;
    reg [3:0]   nxt_hold_len;
    reg [63:0]  nxt_hold_data;

    reg         close_ev;
    reg         can_merge;
    reg         do_merge;
    reg         mergeable_type;
    reg         split;
    reg [2:0]   off;
    reg [3:0]   span;
    reg [3:0]   part_len;
    reg [7:0]   be;
    reg [63:0]  lane_data;
    integer     i;

    wire        gen_done;

    function [7:0] byte_enables;
        input [2:0] o;
        input [3:0] n;
        begin
            byte_enables = ((8'h01 << n) - 8'h01) << o;
        end
    endfunction

    always @* begin
        nxt_state     = state_ff;
        nxt_mode_wt   = mode_wt_ff;
        nxt_line      = line_ff;
        nxt_seq       = seq_ff;
        nxt_mask      = mask_ff;
        nxt_data      = data_ff;
        nxt_tmo       = tmo_ff;
        nxt_hold_v    = hold_v_ff;
        nxt_hold_type = hold_type_ff;
        nxt_hold_addr = hold_addr_ff;
        nxt_hold_len  = hold_len_ff;
        nxt_hold_data = hold_data_ff;
        do_merge      = 1'b0;

        // Only the part up to the quadword boundary is merged per cycle.
        off       = hold_addr_ff[2:0];
        span      = {1'b0, off} + hold_len_ff;
        split     = (span > `WCB_QW_BYTES);
        part_len  = split ? (`WCB_QW_BYTES - {1'b0, off}) : hold_len_ff;
        be        = byte_enables(off, part_len);
        lane_data = hold_data_ff << {off, 3'h0};

        mergeable_type = (hold_type_ff == `WCB_TYPE_WC) ||
                         (hold_type_ff == `WCB_TYPE_WT);

        close_ev = ev_io || ev_serialize || ev_flush || ev_lock_start ||
                   ev_tlb_ad ||
                   (rd_valid && (rd_type == `WCB_TYPE_UC)) ||
                   (rd_valid && (rd_type == `WCB_TYPE_WC) && (rd_addr[31:6] == line_ff));

        can_merge = (hold_addr_ff[31:6] == line_ff) &&
                    (mode_wt_ff ? ((hold_type_ff == `WCB_TYPE_WT) &&
                                   (hold_addr_ff == seq_ff))
                                : (hold_type_ff == `WCB_TYPE_WC));

        case (state_ff)
            `WCB_ST_IDLE: begin
                if (hold_v_ff) begin
                    if (mergeable_type) begin
                        do_merge    = 1'b1;
                        nxt_state   = `WCB_ST_OPEN;
                        nxt_line    = hold_addr_ff[31:6];
                        nxt_mode_wt = (hold_type_ff == `WCB_TYPE_WT);
                    end else begin
                        nxt_hold_v = 1'b0;
                    end
                end
            end
            `WCB_ST_OPEN: begin
                if (close_ev) begin
                    nxt_state = `WCB_ST_DRAIN;
                end else if (hold_v_ff) begin
                    if (hold_type_ff == `WCB_TYPE_WB) begin
                        // Writeback stores bypass the buffer and leave it open.
                        nxt_hold_v = 1'b0;
                    end else if (can_merge) begin
                        do_merge = 1'b1;
                    end else begin
                        // The store waits in the hold slot until the drain ends.
                        nxt_state = `WCB_ST_DRAIN;
                    end
                end else if (mode_wt_ff) begin
                    if (tmo_ff == `WCB_WT_TMO_LAST) begin
                        nxt_state = `WCB_ST_DRAIN;
                    end else begin
                        nxt_tmo = tmo_ff + 5'h01;
                    end
                end
            end
            `WCB_ST_DRAIN: begin
                if (gen_done) begin
                    nxt_mask  = 64'h0000000000000000;
                    nxt_state = `WCB_ST_IDLE;
                end
            end
            default: begin
                nxt_state = `WCB_ST_IDLE;
            end
        endcase

        if (do_merge) begin
            for (i = 0; i < 8; i = i + 1) begin
                if (be[i]) begin
                    nxt_mask[{hold_addr_ff[5:3], 3'h0} + i] = 1'b1;
                    nxt_data[{hold_addr_ff[5:3], 6'h00} + i * 8 +: 8] = lane_data[i * 8 +: 8];
                end
            end
            nxt_tmo = 5'h00;
            nxt_seq = hold_addr_ff + {28'h0000000, part_len};
            if (split) begin
                nxt_hold_addr = {hold_addr_ff[31:3] + 29'h00000001, 3'h0};
                nxt_hold_len  = hold_len_ff - part_len;
                nxt_hold_data = hold_data_ff >> {part_len, 3'h0};
            end else begin
                nxt_hold_v = 1'b0;
            end
            if (&nxt_mask) begin
                nxt_state = `WCB_ST_DRAIN;
            end
            if (nxt_mode_wt && (span >= `WCB_QW_BYTES)) begin
                nxt_state = `WCB_ST_DRAIN;
            end
        end

        // A new store enters only an empty hold slot.
        if (st_valid && st_ready_ff) begin
            nxt_hold_v    = 1'b1;
            nxt_hold_type = st_type;
            nxt_hold_addr = st_addr;
            nxt_hold_len  = st_len;
            nxt_hold_data = st_data;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            state_ff     <= `WCB_ST_IDLE;
            mode_wt_ff   <= 1'b0;
            line_ff      <= 26'h0000000;
            seq_ff       <= 32'h00000000;
            mask_ff      <= 64'h0000000000000000;
            data_ff      <= {512{1'b0}};
            tmo_ff       <= 5'h00;
            hold_v_ff    <= 1'b0;
            hold_type_ff <= `WCB_TYPE_UC;
            hold_addr_ff <= 32'h00000000;
            hold_len_ff  <= 4'h0;
            hold_data_ff <= 64'h0000000000000000;
            st_ready_ff  <= 1'b0;
            open_ff      <= 1'b0;
            start_ff     <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            mode_wt_ff   <= nxt_mode_wt;
            line_ff      <= nxt_line;
            seq_ff       <= nxt_seq;
            mask_ff      <= nxt_mask;
            data_ff      <= nxt_data;
            tmo_ff       <= nxt_tmo;
            hold_v_ff    <= nxt_hold_v;
            hold_type_ff <= nxt_hold_type;
            hold_addr_ff <= nxt_hold_addr;
            hold_len_ff  <= nxt_hold_len;
            hold_data_ff <= nxt_hold_data;
            st_ready_ff  <= !nxt_hold_v;
            open_ff      <= (nxt_state == `WCB_ST_OPEN);
            start_ff     <= (nxt_state == `WCB_ST_DRAIN) && (state_ff != `WCB_ST_DRAIN);
        end
    end

    // The line stays frozen during the drain, so the generator reads it directly.
    wcb_cmd_gen u_cmd_gen (
        .clk          (clk),
        .rst_n        (rst_n),
        .start        (start_ff),
        .line_addr    (line_ff),
        .byte_valid   (mask_ff),
        .line_data    (data_ff),
        .done_ff      (gen_done),
        .cmd_valid_ff (cmd_valid),
        .cmd_kind_ff  (cmd_kind),
        .cmd_addr_ff  (cmd_addr),
        .cmd_mask_ff  (cmd_mask),
        .cmd_data_ff  (cmd_data),
        .cmd_ready    (cmd_ready)
    );

    assign st_ready   = st_ready_ff;
    assign wc_open    = open_ff;
    assign wc_wt_mode = mode_wt_ff;

endmodule // wcb_top

//--- src/wcb_defines.vh
// Constants for the write combining buffer: memory types, bus commands, timing.
`ifndef WCB_DEFINES_VH
`define WCB_DEFINES_VH

`define WCB_TYPE_UC      3'h0
`define WCB_TYPE_WC      3'h1
`define WCB_TYPE_WT      3'h4
`define WCB_TYPE_WP      3'h5
`define WCB_TYPE_WB      3'h6

`define WCB_CMD_QUAD     2'h0
`define WCB_CMD_LONG     2'h1
`define WCB_CMD_BYTE     2'h2

`define WCB_LINE_BYTES   64
`define WCB_QW_BYTES     4'h8
`define WCB_WT_TMO_CLKS  16
`define WCB_WT_TMO_LAST  5'h0F

`define WCB_ST_IDLE      2'h0
`define WCB_ST_OPEN      2'h1
`define WCB_ST_DRAIN     2'h2

`define WCB_GEN_QUAD     2'h0
`define WCB_GEN_LONG     2'h1
`define WCB_GEN_STEP     2'h2

`endif

//--- src/wcb_cmd_gen.v
// Turns a closed line buffer into a sequence of system bus write commands.
`timescale 1ns/1ns
`include "wcb_defines.vh"

module wcb_cmd_gen (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // Closed buffer
    input  wire         start,
    input  wire [25:0]  line_addr,
    input  wire [63:0]  byte_valid,
    input  wire [511:0] line_data,
    output reg          done_ff,
    // Bus command
    output reg          cmd_valid_ff,
    output reg  [1:0]   cmd_kind_ff,
    output reg  [31:0]  cmd_addr_ff,
    output reg  [7:0]   cmd_mask_ff,
    output reg  [511:0] cmd_data_ff,
    input  wire         cmd_ready
);

    localparam G_IDLE = 2'h0;
    localparam G_PICK = 2'h1;
    localparam G_SEND = 2'h2;

    reg [1:0] gst_ff;
    reg [1:0] mode_ff;
    reg [2:0] idx_ff;
    reg       last_ff;

    reg       all_q;
    reg       all_l;
    reg [7:0] qv;
    reg [7:0] qm;
    reg [7:0] lm;
    reg       is_last;
    integer   k;

    function [7:0] qw_bytes;
        input [63:0] m;
        input [2:0]  q;
        begin
            qw_bytes = m[{q, 3'h0} +: 8];
        end
    endfunction

    function [7:0] half_longs;
        input [63:0] m;
        input        h;
        integer      j;
        begin
            for (j = 0; j < 8; j = j + 1) begin
                half_longs[j] = &m[{h, 5'h00} + j * 4 +: 4];
            end
        end
    endfunction

    always @* begin
        all_q = 1'b1;
        all_l = 1'b1;
        for (k = 0; k < 8; k = k + 1) begin
            qv[k] = &qw_bytes(byte_valid, k[2:0]);
            if (qw_bytes(byte_valid, k[2:0]) != 8'h00 && !qv[k]) begin
                all_q = 1'b0;
            end
        end
        for (k = 0; k < 16; k = k + 1) begin
            if (byte_valid[k * 4 +: 4] != 4'h0 && byte_valid[k * 4 +: 4] != 4'hF) begin
                all_l = 1'b0;
            end
        end
        qm      = qw_bytes(byte_valid, idx_ff);
        lm      = half_longs(byte_valid, idx_ff[0]);
        is_last = (mode_ff == `WCB_GEN_LONG) ? idx_ff[0] : (idx_ff == 3'h7);
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            gst_ff       <= G_IDLE;
            mode_ff      <= `WCB_GEN_QUAD;
            idx_ff       <= 3'h0;
            last_ff      <= 1'b0;
            done_ff      <= 1'b0;
            cmd_valid_ff <= 1'b0;
            cmd_kind_ff  <= `WCB_CMD_QUAD;
            cmd_addr_ff  <= 32'h00000000;
            cmd_mask_ff  <= 8'h00;
            cmd_data_ff  <= {512{1'b0}};
        end else begin
            done_ff <= 1'b0;
            case (gst_ff)
                G_IDLE: begin
                    if (start) begin
                        idx_ff  <= 3'h0;
                        gst_ff  <= G_PICK;
                        mode_ff <= all_q ? `WCB_GEN_QUAD :
                                   (all_l ? `WCB_GEN_LONG : `WCB_GEN_STEP);
                    end
                end
                G_PICK: begin
                    cmd_data_ff <= line_data;
                    last_ff     <= is_last;
                    if (mode_ff == `WCB_GEN_QUAD) begin
                        cmd_kind_ff  <= `WCB_CMD_QUAD;
                        cmd_addr_ff  <= {line_addr, 6'h00};
                        cmd_mask_ff  <= qv;
                        cmd_valid_ff <= 1'b1;
                        last_ff      <= 1'b1;
                        gst_ff       <= G_SEND;
                    end else if (mode_ff == `WCB_GEN_LONG && lm != 8'h00) begin
                        cmd_kind_ff  <= `WCB_CMD_LONG;
                        cmd_addr_ff  <= {line_addr, idx_ff[0], 5'h00};
                        cmd_mask_ff  <= lm;
                        cmd_valid_ff <= 1'b1;
                        gst_ff       <= G_SEND;
                    end else if (mode_ff == `WCB_GEN_STEP && qm != 8'h00) begin
                        cmd_valid_ff <= 1'b1;
                        gst_ff       <= G_SEND;
                        if (qm == 8'hFF) begin
                            cmd_kind_ff <= `WCB_CMD_QUAD;
                            cmd_addr_ff <= {line_addr, 6'h00};
                            cmd_mask_ff <= 8'h01 << idx_ff;
                        end else if (qm == 8'h0F || qm == 8'hF0) begin
                            cmd_kind_ff <= `WCB_CMD_LONG;
                            cmd_addr_ff <= {line_addr, idx_ff[2], 5'h00};
                            cmd_mask_ff <= 8'h01 << {idx_ff[1:0], qm[7]};
                        end else begin
                            cmd_kind_ff <= `WCB_CMD_BYTE;
                            cmd_addr_ff <= {line_addr, idx_ff, 3'h0};
                            cmd_mask_ff <= qm;
                        end
                    end else if (is_last) begin
                        done_ff <= 1'b1;
                        gst_ff  <= G_IDLE;
                    end else begin
                        idx_ff <= idx_ff + 3'h1;
                    end
                end
                G_SEND: begin
                    if (cmd_ready) begin
                        cmd_valid_ff <= 1'b0;
                        if (last_ff) begin
                            done_ff <= 1'b1;
                            gst_ff  <= G_IDLE;
                        end else begin
                            idx_ff <= idx_ff + 3'h1;
                            gst_ff <= G_PICK;
                        end
                    end
                end
                default: begin
                    gst_ff <= G_IDLE;
                end
            endcase
        end
    end

endmodule // wcb_cmd_gen

//--- tb/wcb_chk.sv
// Port-level assertions for the write combining buffer.
`timescale 1ns/1ns
`include "wcb_defines.vh"

module wcb_chk (
    // Clock and reset
    input wire        clk,
    input wire        rst_n,
    // Store path
    input wire        st_valid,
    input wire [2:0]  st_type,
    input wire        st_ready,
    // Closing events and reads
    input wire        ev_io,
    input wire        ev_serialize,
    input wire        ev_flush,
    input wire        ev_lock_start,
    input wire        ev_tlb_ad,
    input wire        rd_valid,
    input wire [2:0]  rd_type,
    // Bus command and status
    input wire        cmd_valid,
    input wire [1:0]  cmd_kind,
    input wire [31:0] cmd_addr,
    input wire [7:0]  cmd_mask,
    input wire        cmd_ready,
    input wire        wc_open,
    input wire        wc_wt_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire ev_any = ev_io | ev_serialize | ev_flush | ev_lock_start | ev_tlb_ad;
    wire st_take = st_valid & st_ready;
    wire st_plain = st_type == `WCB_TYPE_UC || st_type == `WCB_TYPE_WP || st_type == `WCB_TYPE_WB;
    // Idle clocks of an open write-through buffer; a lost time-out shows as a runaway count.
    reg [5:0] wt_idle_ff;
    always @(posedge clk) begin
        if (!rst_n || !(wc_open && wc_wt_mode) || st_take)
            wt_idle_ff <= 6'h00;
        else if (wt_idle_ff != 6'h3F)
            wt_idle_ff <= wt_idle_ff + 6'h01;
    end
    chk_event_close:
        assert property (wc_open && ev_any |=> !wc_open) else $error("Event left buffer open.");
    chk_uc_read:
        assert property (wc_open && rd_valid && rd_type == `WCB_TYPE_UC |=> !wc_open)
            else $error("Uncacheable read left buffer open.");
    chk_cmd_hold:
        assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_kind)
            && $stable(cmd_addr) && $stable(cmd_mask)) else $error("Command changed while stalled.");
    chk_cmd_align:
        assert property (cmd_valid |-> (cmd_kind == `WCB_CMD_QUAD && cmd_addr[5:0] == 6'h00)
            || (cmd_kind == `WCB_CMD_LONG && cmd_addr[4:0] == 5'h00)
            || (cmd_kind == `WCB_CMD_BYTE && cmd_addr[2:0] == 3'h0))
            else $error("Command kind or address misaligned.");
    chk_cmd_mask:
        assert property (cmd_valid |-> cmd_mask != 8'h00) else $error("Command with empty mask.");
    chk_drain_shut:
        assert property (cmd_valid |-> !wc_open) else $error("Buffer open while draining.");
    chk_plain_store:
        assert property (st_take && st_plain && !wc_open |=> !wc_open [*2])
            else $error("Unmergeable store opened a buffer.");
    chk_wt_timeout:
        assert property (wt_idle_ff <= 6'h14) else $error("Write-through buffer never timed out.");
    chk_type_swap:
        assert property (wc_open && st_take && ((wc_wt_mode && st_type == `WCB_TYPE_WC)
            || (!wc_wt_mode && st_type == `WCB_TYPE_WT))
            |-> ##[1:3] !wc_open) else $error("Type change kept buffer open.");
    cover property (cmd_valid && cmd_ready && cmd_kind == `WCB_CMD_QUAD);
    cover property (cmd_valid && cmd_ready && cmd_kind == `WCB_CMD_LONG);
    cover property (cmd_valid && cmd_ready && cmd_kind == `WCB_CMD_BYTE);
    cover property (wc_open && wc_wt_mode && st_take);
endmodule // wcb_chk

bind wcb_top wcb_chk wcb_chk_i (.clk, .rst_n, .st_valid, .st_type, .st_ready, .ev_io,
    .ev_serialize, .ev_flush, .ev_lock_start, .ev_tlb_ad, .rd_valid, .rd_type, .cmd_valid,
    .cmd_kind, .cmd_addr, .cmd_mask, .cmd_ready, .wc_open, .wc_wt_mode);

//--- tb/wcb_bus_model.sv
// Bus command sink standing in for the system bus interface.
`timescale 1ns/1ns

module wcb_bus_model (
    // Clock and reset
    input wire         clk,
    input wire         rst_n,
    // Bus command from the buffer
    input wire         cmd_valid,
    input wire [1:0]   cmd_kind,
    input wire [31:0]  cmd_addr,
    input wire [7:0]   cmd_mask,
    input wire [511:0] cmd_data,
    output reg         cmd_ready,
    // Back-pressure request from the bench
    input wire         stall
);
    // Every accepted command is logged so the bench can compare whole sequences later.
    logic [1:0]   log_kind [64];
    logic [31:0]  log_addr [64];
    logic [7:0]   log_mask [64];
    logic [511:0] log_data [64];
    int           n_cmd = 0;
    always @(posedge clk) begin
        cmd_ready <= rst_n && !stall;
        if (rst_n && cmd_valid && cmd_ready) begin
            log_kind[n_cmd[5:0]] <= cmd_kind;
            log_addr[n_cmd[5:0]] <= cmd_addr;
            log_mask[n_cmd[5:0]] <= cmd_mask;
            log_data[n_cmd[5:0]] <= cmd_data;
            n_cmd <= n_cmd + 1;
        end
    end
endmodule // wcb_bus_model

//--- tb/wcb_top_test.sv
// Self-checking bench for the write combining buffer.
`timescale 1ns/1ns
`include "wcb_defines.vh"

module wcb_top_test;
    typedef struct {logic [2:0] t; logic [31:0] a; logic [3:0] n; logic [2:0] ev;
        logic [1:0] k; logic [31:0] ca; logic [7:0] m;} wcb_row_t;
    logic         clk, rst_n, st_valid, rd_valid, stall;
    logic [2:0]   st_type, rd_type;
    logic [31:0]  st_addr, rd_addr;
    logic [3:0]   st_len;
    logic [63:0]  st_data;
    logic [4:0]   evs;
    wire          st_ready, cmd_valid, cmd_ready, wc_open, wc_wt_mode;
    wire  [1:0]   cmd_kind;
    wire  [31:0]  cmd_addr;
    wire  [7:0]   cmd_mask;
    wire  [511:0] cmd_data;
    int           n_mismatch = 0, n_compared = 0, base = 0, cur = 0;
    wcb_row_t     rows [5] = '{
        '{`WCB_TYPE_WC, 32'h1000_0008, 4'h8, 3'h2, `WCB_CMD_QUAD, 32'h1000_0000, 8'h02},
        '{`WCB_TYPE_WC, 32'h1000_0014, 4'h4, 3'h1, `WCB_CMD_LONG, 32'h1000_0000, 8'h20},
        '{`WCB_TYPE_WC, 32'h1000_0023, 4'h2, 3'h0, `WCB_CMD_BYTE, 32'h1000_0020, 8'h18},
        '{`WCB_TYPE_WT, 32'h2000_0030, 4'h4, 3'h3, `WCB_CMD_LONG, 32'h2000_0020, 8'h10},
        '{`WCB_TYPE_WT, 32'h2000_0041, 4'h1, 3'h4, `WCB_CMD_BYTE, 32'h2000_0040, 8'h02}};

    wcb_top wcb_top_i (.clk, .rst_n, .st_valid, .st_type, .st_addr, .st_len, .st_data,
        .st_ready, .ev_io(evs[0]), .ev_serialize(evs[1]), .ev_flush(evs[2]),
        .ev_lock_start(evs[3]), .ev_tlb_ad(evs[4]), .rd_valid, .rd_type, .rd_addr, .cmd_valid,
        .cmd_kind, .cmd_addr, .cmd_mask, .cmd_data, .cmd_ready, .wc_open, .wc_wt_mode);
    wcb_bus_model wcb_bus_model_i (.clk, .rst_n, .cmd_valid, .cmd_kind, .cmd_addr, .cmd_mask,
        .cmd_data, .cmd_ready, .stall);

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // The store waits for ready at the falling edge so the launch never races the design.
    task automatic store(input logic [2:0] t, input logic [31:0] a, input logic [3:0] n,
        input logic [63:0] d);
        int k;
        k = 0;
        @(negedge clk);
        while (st_ready !== 1'b1 && k < 200) begin
            @(negedge clk);
            k++;
        end
        if (k == 200) begin
            n_mismatch++;
            end_sim;
        end
        @(posedge clk);
        st_valid <= 1'b1;
        st_type <= t;
        st_addr <= a;
        st_len <= n;
        st_data <= d;
        @(posedge clk);
        st_valid <= 1'b0;
    endtask
    task automatic pulse(input logic [2:0] b);
        @(posedge clk);
        evs <= 5'h01 << b;
        @(posedge clk);
        evs <= 5'h00;
    endtask
    task automatic read(input logic [2:0] t, input logic [31:0] a);
        @(posedge clk);
        rd_valid <= 1'b1;
        rd_type <= t;
        rd_addr <= a;
        @(posedge clk);
        rd_valid <= 1'b0;
    endtask
    task automatic see_open(input logic exp, input int wait_n);
        repeat (wait_n) @(posedge clk);
        @(negedge clk);
        check("wc_open", wc_open, exp);
    endtask
    task automatic drain(input int n);
        int k;
        k = 0;
        while (wcb_bus_model_i.n_cmd < base + n && k < 300) begin
            @(negedge clk);
            k++;
        end
        if (k == 300) begin
            n_mismatch++;
            end_sim;
        end
        repeat (8) @(negedge clk);
        check("command count", wcb_bus_model_i.n_cmd, base + n);
        cur = base;
        base += n;
    endtask
    task automatic cmd(input int j, input logic [1:0] kd, input logic [31:0] a,
        input logic [7:0] m);
        check("cmd_kind", wcb_bus_model_i.log_kind[cur + j], kd);
        check("cmd_addr", wcb_bus_model_i.log_addr[cur + j], a);
        check("cmd_mask", wcb_bus_model_i.log_mask[cur + j], m);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        {rst_n, st_valid, rd_valid, stall, evs} = 9'h000;
        {st_type, rd_type, st_addr, rd_addr, st_len, st_data} = 138'h0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("reset outputs", {st_ready, cmd_valid, wc_open}, 3'h0);
        @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            store(rows[i].t, rows[i].a, rows[i].n, 64'hFFEE_DDCC_BBAA_9988);
            see_open(1'b1, 3);
            check("wc_wt_mode", wc_wt_mode, rows[i].t == `WCB_TYPE_WT);
            pulse(rows[i].ev);
            drain(1);
            cmd(0, rows[i].k, rows[i].ca, rows[i].m);
            check("line byte", wcb_bus_model_i.log_data[cur][8 * rows[i].a[5:0] +: 8], 8'h88);
        end
        store(`WCB_TYPE_WT, 32'h3000_0000, 4'h2, 64'h0);
        see_open(1'b1, 10);
        drain(1);
        cmd(0, `WCB_CMD_BYTE, 32'h3000_0000, 8'h03);
        store(`WCB_TYPE_WC, 32'h4000_0000, 4'h8, 64'h0);
        see_open(1'b1, 40);
        read(`WCB_TYPE_WC, 32'h4000_0100);
        see_open(1'b1, 2);
        read(`WCB_TYPE_WC, 32'h4000_0020);
        drain(1);
        store(`WCB_TYPE_WT, 32'h4100_0000, 4'h1, 64'h0);
        see_open(1'b1, 3);
        read(`WCB_TYPE_UC, 32'h5000_0000);
        drain(1);
        for (int i = 2; i < 8; i += 2)
            store(`WCB_TYPE_WT, 32'h5000_0000 + 32'(i), 4'h2, 64'h0);
        drain(1);
        cmd(0, `WCB_CMD_BYTE, 32'h5000_0000, 8'hFC);
        store(`WCB_TYPE_WT, 32'h5000_0010, 4'h1, 64'h0);
        store(`WCB_TYPE_WT, 32'h5000_0013, 4'h1, 64'h0);
        drain(2);
        cmd(0, `WCB_CMD_BYTE, 32'h5000_0010, 8'h01);
        cmd(1, `WCB_CMD_BYTE, 32'h5000_0010, 8'h08);
        store(`WCB_TYPE_WC, 32'h6000_0000, 4'h8, 64'h0);
        store(`WCB_TYPE_WT, 32'h6000_0008, 4'h8, 64'h0);
        drain(2);
        cmd(0, `WCB_CMD_QUAD, 32'h6000_0000, 8'h01);
        cmd(1, `WCB_CMD_QUAD, 32'h6000_0000, 8'h02);
        @(posedge clk);
        stall <= 1'b1;
        for (int i = 7; i >= 0; i--)
            store(`WCB_TYPE_WC, 32'h7000_0000 + 32'(8 * i), 4'h8, {8{8'hA0 + i[7:0]}});
        see_open(1'b0, 20);
        check("cmd_valid", cmd_valid, 1'b1);
        @(posedge clk);
        stall <= 1'b0;
        drain(1);
        cmd(0, `WCB_CMD_QUAD, 32'h7000_0000, 8'hFF);
        check("line low", wcb_bus_model_i.log_data[cur][63:0], {8{8'hA0}});
        check("line high", wcb_bus_model_i.log_data[cur][511:448], {8{8'hA7}});
        store(`WCB_TYPE_WB, 32'h8000_0000, 4'h8, 64'h0);
        see_open(1'b0, 3);
        store(`WCB_TYPE_UC, 32'h8000_0000, 4'h8, 64'h0);
        see_open(1'b0, 3);
        store(`WCB_TYPE_WC, 32'h8000_0000, 4'h8, 64'h0);
        store(`WCB_TYPE_WC, 32'h8000_0040, 4'h8, 64'h0);
        store(`WCB_TYPE_WB, 32'h9900_0000, 4'h8, 64'h0);
        see_open(1'b1, 3);
        store(`WCB_TYPE_WP, 32'h8100_0000, 4'h1, 64'h0);
        drain(2);
        cmd(0, `WCB_CMD_QUAD, 32'h8000_0000, 8'h01);
        cmd(1, `WCB_CMD_QUAD, 32'h8000_0040, 8'h01);
        store(`WCB_TYPE_WT, 32'h9000_0006, 4'h4, 64'h0);
        drain(2);
        cmd(0, `WCB_CMD_BYTE, 32'h9000_0000, 8'hC0);
        cmd(1, `WCB_CMD_BYTE, 32'h9000_0008, 8'h03);
        end_sim;
    end
endmodule // wcb_top_test
